// >>> common/tsf_defines.svh
// tsf_defines.svh: offsets, field positions, reset values and counts of the
// transfer status flag block; definitions only, included by bare name
`ifndef TSF_DEFINES_SVH
`define TSF_DEFINES_SVH

// register bus widths
`define TSF_ADDR_W 8
`define TSF_DATA_W 8

// register byte offsets
`define TSF_OFS_CTRL 8'h00
`define TSF_OFS_FLAGS 8'h04
`define TSF_OFS_ISTAT 8'h08
`define TSF_OFS_IMASK 8'h0C

// control register fields
`define TSF_CTRL_EN 0
`define TSF_CTRL_MST 1
`define TSF_CTRL_SAVE 2
`define TSF_CTRL_WREL 3

// flag register fields
`define TSF_FLG_DIR 0
`define TSF_FLG_ACK 1
`define TSF_FLG_STD 2
`define TSF_FLG_DRV 3
`define TSF_FLG_CNT_LO 4
`define TSF_FLG_CNT_HI 7

// interrupt event fields
`define TSF_EV_W 4

// reset values
`define TSF_RST_BYTE 8'h00
`define TSF_RST_EV 4'h0
`define TSF_RST_CNT 4'h0

// serial clock numbers within a byte
`define TSF_CNT_W 4
`define TSF_CLK_ONE 4'h1
`define TSF_CLK_DIRBIT 4'h8
`define TSF_CLK_ACK 4'h9

`endif

// >>> common/tsf_pkg.sv
// tsf_pkg: types shared by the transfer status flag block
// assumes tsf_defines.svh sits on the include path
package tsf_pkg;
  `include "tsf_defines.svh"

  // the three bus flags, as software and the pins see them
  typedef struct packed {
    logic start_detected_flag;
    logic ack_detected_flag;
    logic direction_flag;
  } tsf_flags_t;

  // interrupt events, same layout in status and mask
  typedef struct packed {
    logic alost;
    logic ack;
    logic stop;
    logic start;
  } tsf_event_t;

  // transfer phase, one-hot
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_ADDR = 3'b010,
    PH_DATA = 3'b100
  } tsf_phase_t;
endpackage

// >>> rtl/tsf_pin_sync.sv
// tsf_pin_sync: three-stage synchroniser for one pin input
// assumes the pin is asynchronous to clk; output changes once stages two and three agree
`timescale 1ns/100ps
module tsf_pin_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and clean level
  input wire logic pin_in,
  output logic level_ff
);
  logic meta_ff; // first stage, read only by the second
  logic s2_ff;
  logic s3_ff;

  // shift chain; idle bus level is high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end
    else
    begin
      meta_ff <= pin_in;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
    end
  end

  // accept a change only when the two settled stages agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      level_ff <= 1'b1;
    else if (s2_ff == s3_ff)
      level_ff <= s3_ff;
  end
endmodule

// >>> rtl/tsf_flag_cell.sv
// tsf_flag_cell: one hardware flag with set and clear terms
// assumes both terms come from logic on the same clock
`timescale 1ns/100ps
module tsf_flag_cell
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // set and clear terms
  input wire logic set,
  input wire logic clr,
  // flag value
  output logic flag_ff
);
  // set wins so an event in the clearing cycle is not lost
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_ff <= 1'b0;
    else if (set)
      flag_ff <= 1'b1;
    else if (clr)
      flag_ff <= 1'b0;
  end
endmodule

// >>> rtl/tsf_status_flags.sv
// tsf_status_flags: direction, acknowledge and start-detected flags of one
// two-wire serial channel, plus the data-line drive control
// assumes scl/sda pins are asynchronous; shift latch, start generation,
// ninth-clock wait and arbitration flag come from logic on CLK
`timescale 1ns/100ps
`include "tsf_defines.svh"

module tsf_status_flags
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // register bus
  input wire logic [`TSF_ADDR_W-1:0] ADDR,
  input wire logic [`TSF_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [`TSF_DATA_W-1:0] RDATA,
  // two-wire bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // companion channel logic
  input wire logic SO_LATCH,
  input wire logic START_GEN,
  input wire logic WAIT_NINTH,
  input wire logic ARB_LOST,
  // status outputs
  output tsf_pkg::tsf_flags_t FLAGS,
  output logic IRQ
);
  import tsf_pkg::*;

  // reset release chain
  logic rst_meta_ff;
  logic rst_n; // synchronised reset used by all logic

  // clean pin levels and their previous values
  logic scl_s;
  logic sda_s;
  logic scl_prev_ff;
  logic sda_prev_ff;

  // control register
  logic channel_enable_ff;
  logic master_ff;
  logic comm_save_cmd; // one-cycle command pulse from a control write
  logic wait_release_cmd; // one-cycle command pulse from a control write
  logic en_prev_ff;
  logic alost_prev_ff;

  // byte tracking
  tsf_phase_t phase_ff;
  tsf_phase_t nxt_phase;
  logic [`TSF_CNT_W-1:0] clk_cnt_ff;
  logic [`TSF_CNT_W-1:0] nxt_clk_cnt;

  // bus events
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic en_fall;
  logic alost_rise;
  logic dir_bit_clk; // rising edge that samples the direction bit
  logic ack_clk; // ninth rising edge
  logic next_byte_clk; // first rising edge of a following byte

  // flag terms
  logic dir_set;
  logic dir_clr;
  logic ack_set;
  logic ack_clr;
  logic std_set;
  logic std_clr;
  tsf_flags_t flags;
  logic drive_phase;

  // interrupt state
  tsf_event_t ev;
  tsf_event_t istat_ff;
  tsf_event_t imask_ff;
  tsf_event_t nxt_istat;

  // register output copies
  logic [`TSF_DATA_W-1:0] rdata_ff;
  logic [`TSF_DATA_W-1:0] nxt_rdata;
  logic sda_out_ff;
  logic sda_oe_n_ff;
  logic irq_ff;

  // reset release: asserts at once, releases after two edges
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // pin synchronisers
  tsf_pin_sync u_scl_sync
  (
    .clk(CLK),
    .rst_n(rst_n),
    .pin_in(SCL_IN),
    .level_ff(scl_s)
  );

  tsf_pin_sync u_sda_sync
  (
    .clk(CLK),
    .rst_n(rst_n),
    .pin_in(SDA_IN),
    .level_ff(sda_s)
  );

  // previous pin and input levels for edge detection
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      en_prev_ff <= 1'b0;
      alost_prev_ff <= 1'b0;
    end
    else
    begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      en_prev_ff <= channel_enable_ff;
      alost_prev_ff <= ARB_LOST;
    end
  end

  // edges and bus conditions; start and stop only while clock stays high
  assign scl_rise = scl_s & ~scl_prev_ff;
  assign scl_fall = ~scl_s & scl_prev_ff;
  assign start_cond = channel_enable_ff & scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign stop_cond = channel_enable_ff & scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  assign en_fall = en_prev_ff & ~channel_enable_ff;
  assign alost_rise = ARB_LOST & ~alost_prev_ff;

  // edge classification by clock number within the byte
  assign dir_bit_clk = scl_rise & (phase_ff == PH_ADDR)
    & (nxt_clk_cnt == `TSF_CLK_DIRBIT);
  assign ack_clk = scl_rise & (phase_ff != PH_IDLE) & (nxt_clk_cnt == `TSF_CLK_ACK);
  assign next_byte_clk = scl_rise & (clk_cnt_ff == `TSF_CLK_ACK);

  // clock counter: 1..9 per byte, restarts on a start condition
  always_comb
  begin
    nxt_clk_cnt = clk_cnt_ff;
    if (!channel_enable_ff || start_cond)
      nxt_clk_cnt = `TSF_RST_CNT;
    else if (scl_rise)
    begin
      if (clk_cnt_ff == `TSF_CLK_ACK)
        nxt_clk_cnt = `TSF_CLK_ONE;
      else
        nxt_clk_cnt = clk_cnt_ff + `TSF_CLK_ONE;
    end
  end

  // phase: address byte until the falling edge of its ninth clock
  always_comb
  begin
    nxt_phase = phase_ff;
    unique case (phase_ff)
      PH_IDLE:
        if (start_cond)
          nxt_phase = PH_ADDR;
      PH_ADDR:
        if (scl_fall && clk_cnt_ff == `TSF_CLK_ACK)
          nxt_phase = PH_DATA;
      PH_DATA:
        if (start_cond)
          nxt_phase = PH_ADDR; // repeated start
      default:
        nxt_phase = PH_IDLE; // illegal code recovers to idle
    endcase
    // release of the bus ends any transfer
    if (!channel_enable_ff || stop_cond || comm_save_cmd)
      nxt_phase = PH_IDLE;
    else if (start_cond)
      nxt_phase = PH_ADDR;
  end

  // phase and counter registers
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_ff <= PH_IDLE;
      clk_cnt_ff <= `TSF_RST_CNT;
    end
    else
    begin
      phase_ff <= nxt_phase;
      clk_cnt_ff <= nxt_clk_cnt;
    end
  end

  // direction flag terms; all sets need the channel enabled
  assign dir_set = channel_enable_ff & (
    (master_ff & START_GEN)
    | (dir_bit_clk & master_ff & ~SO_LATCH)
    | (dir_bit_clk & ~master_ff & sda_s));
  assign dir_clr = ~channel_enable_ff | en_fall | stop_cond | comm_save_cmd
    | wait_release_cmd
    | alost_rise
    | (dir_bit_clk & master_ff & SO_LATCH);

  // acknowledge flag terms
  assign ack_set = channel_enable_ff & ack_clk & ~sda_s;
  assign ack_clr = ~channel_enable_ff | en_fall | stop_cond | comm_save_cmd
    | next_byte_clk;

  // start-detected flag terms
  assign std_set = start_cond;
  assign std_clr = ~channel_enable_ff | en_fall | stop_cond | comm_save_cmd
    | (next_byte_clk & (phase_ff == PH_DATA) & flags.start_detected_flag);

  // flag cells: only bus events and commands reach them, never data writes
  tsf_flag_cell u_dir_flag
  (
    .clk(CLK),
    .rst_n(rst_n),
    .set(dir_set),
    .clr(dir_clr),
    .flag_ff(flags.direction_flag)
  );

  tsf_flag_cell u_ack_flag
  (
    .clk(CLK),
    .rst_n(rst_n),
    .set(ack_set),
    .clr(ack_clr),
    .flag_ff(flags.ack_detected_flag)
  );

  tsf_flag_cell u_std_flag
  (
    .clk(CLK),
    .rst_n(rst_n),
    .set(std_set),
    .clr(std_clr),
    .flag_ff(flags.start_detected_flag)
  );

  // a master sends its own address, a slave transmits only after the address
  assign drive_phase = (phase_ff == PH_DATA) | master_ff;

  // data-line drive; released the same cycle any clearing term fires
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_out_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1; // released out of reset
    end
    else
    begin
      sda_out_ff <= SO_LATCH;
      if (flags.direction_flag && drive_phase && !dir_clr)
        sda_oe_n_ff <= 1'b0;
      else if (wait_release_cmd && WAIT_NINTH)
        sda_oe_n_ff <= 1'b1;
      else
        sda_oe_n_ff <= 1'b1;
    end
  end

  // control register; command bits are pulses and read back as zero
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      channel_enable_ff <= 1'b0;
      master_ff <= 1'b0;
      comm_save_cmd <= 1'b0;
      wait_release_cmd <= 1'b0;
    end
    else
    begin
      comm_save_cmd <= 1'b0;
      wait_release_cmd <= 1'b0;
      if (WR && ADDR == `TSF_OFS_CTRL)
      begin
        channel_enable_ff <= WDATA[`TSF_CTRL_EN];
        master_ff <= WDATA[`TSF_CTRL_MST];
        comm_save_cmd <= WDATA[`TSF_CTRL_SAVE];
        wait_release_cmd <= WDATA[`TSF_CTRL_WREL];
      end
    end
  end

  // interrupt events, one cycle each
  assign ev.start = start_cond;
  assign ev.stop = stop_cond;
  assign ev.ack = ack_set;
  assign ev.alost = alost_rise;

  // sticky status: write one clears, a new event in the same cycle wins
  always_comb
  begin
    nxt_istat = istat_ff;
    if (WR && ADDR == `TSF_OFS_ISTAT)
      nxt_istat = istat_ff & ~tsf_event_t'(WDATA[`TSF_EV_W-1:0]);
    nxt_istat = nxt_istat | ev;
  end

  // status, mask and interrupt line
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      istat_ff <= `TSF_RST_EV;
      imask_ff <= `TSF_RST_EV;
      irq_ff <= 1'b0;
    end
    else
    begin
      istat_ff <= nxt_istat;
      if (WR && ADDR == `TSF_OFS_IMASK)
        imask_ff <= WDATA[`TSF_EV_W-1:0];
      irq_ff <= |(nxt_istat & imask_ff);
    end
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    nxt_rdata = `TSF_RST_BYTE;
    if (RD)
    begin
      unique case (ADDR)
        `TSF_OFS_CTRL:
        begin
          nxt_rdata[`TSF_CTRL_EN] = channel_enable_ff;
          nxt_rdata[`TSF_CTRL_MST] = master_ff;
        end
        `TSF_OFS_FLAGS:
        begin
          nxt_rdata[`TSF_FLG_DIR] = flags.direction_flag;
          nxt_rdata[`TSF_FLG_ACK] = flags.ack_detected_flag;
          nxt_rdata[`TSF_FLG_STD] = flags.start_detected_flag;
          nxt_rdata[`TSF_FLG_DRV] = ~sda_oe_n_ff;
          nxt_rdata[`TSF_FLG_CNT_HI:`TSF_FLG_CNT_LO] = clk_cnt_ff;
        end
        `TSF_OFS_ISTAT:
          nxt_rdata[`TSF_EV_W-1:0] = istat_ff;
        `TSF_OFS_IMASK:
          nxt_rdata[`TSF_EV_W-1:0] = imask_ff;
        default:
          nxt_rdata = `TSF_RST_BYTE;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= `TSF_RST_BYTE;
    else
      rdata_ff <= nxt_rdata;
  end

  // the flag register is read-only: writes to its offset do nothing
  assign FLAGS = flags;
  assign RDATA = rdata_ff;
  assign SDA_OUT = sda_out_ff;
  assign SDA_OE_N = sda_oe_n_ff;
  assign IRQ = irq_ff;
endmodule

// >>> bench/tsf_status_flags_asserts.sv
// tsf_chk: port-level checks of the status flag block
// assumes one clock; bound into every tsf_status_flags instance below
`timescale 1ns/100ps
`include "tsf_defines.svh"
module tsf_chk
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // register writes
  input wire logic [`TSF_ADDR_W-1:0] ADDR,
  input wire logic [`TSF_DATA_W-1:0] WDATA,
  input wire logic WR,
  // pins and companion inputs
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic SO_LATCH,
  input wire logic ARB_LOST,
  // flags
  input wire tsf_pkg::tsf_flags_t FLAGS
);
  import tsf_pkg::*;
  // write to the control register
  logic ctl_wr;
  assign ctl_wr = WR && ADDR == `TSF_OFS_CTRL;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // two cycles of receive leave room for the registered enable
  rx_release_a: assert property (!FLAGS.direction_flag [*2] |-> SDA_OE_N)
    else $error("data line driven while receiving");
  tx_value_a: assert property (!SDA_OE_N |-> SDA_OUT == $past(SO_LATCH))
    else $error("driven value is not the shift latch");
  drive_dir_a: assert property ($fell(SDA_OE_N) |-> FLAGS.direction_flag)
    else $error("drive began without transmit direction");
  arb_clear_a: assert property ($rose(ARB_LOST) |-> ##[1:2] !FLAGS.direction_flag)
    else $error("arbitration loss left direction set");
  cmd_clear_a: assert property (ctl_wr && (!WDATA[`TSF_CTRL_EN] || WDATA[`TSF_CTRL_SAVE])
    |-> ##[1:2] FLAGS == 3'h0)
    else $error("disable or save left a flag set");
  wrel_clear_a: assert property (ctl_wr && WDATA[`TSF_CTRL_WREL]
    |-> ##[1:3] (!FLAGS.direction_flag && SDA_OE_N))
    else $error("wait release kept transmit");
  sw_write_a: assert property (WR && ADDR != `TSF_OFS_CTRL |=> $stable(FLAGS))
    else $error("register write moved a flag");
  ack_low_a: assert property ($rose(FLAGS.ack_detected_flag) |-> SCL_IN && !SDA_IN)
    else $error("ack flag set without low data at clock high");
  start_seen_a: assert property ($rose(FLAGS.start_detected_flag) |-> SCL_IN && !SDA_IN)
    else $error("start flag set outside a start condition");
  // main scenarios reached
  cover property ($rose(FLAGS.direction_flag));
  cover property ($rose(FLAGS.ack_detected_flag));
  cover property ($fell(SDA_OE_N));
endmodule

bind tsf_status_flags tsf_chk i_chk
(
  .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
  .SO_LATCH(SO_LATCH), .ARB_LOST(ARB_LOST), .FLAGS(FLAGS)
);

// >>> bench/tsf_bus_peer.sv
// tsf_bus_peer: remote party on the two-wire bus, making the clock and data
// assumes a pull-up on the data line; every phase starts on a clock edge
`timescale 1ns/100ps
module tsf_bus_peer
(
  // bench clock
  input wire logic clk,
  // device side of the data line
  input wire logic dev_out,
  input wire logic dev_oe_n,
  // bus levels seen by the device
  output logic scl,
  output logic sda
);
  // own open-drain drive, 1 means released
  logic drv = 1'b1;
  // cycles per phase; the bench sets it row by row from 7 up to 19 to act as a slow party
  int half = 8;
  initial scl = 1'b1;
  // wired-and with pull-up, so a released line reads high, never stale
  assign sda = drv & (dev_oe_n | dev_out);
  // one phase: clock level c, own data d
  task automatic line(input logic c, input logic d);
    @(posedge clk);
    scl <= c;
    drv <= d;
    repeat (half - 1) @(posedge clk);
  endtask
  // data changes only while the clock is low
  task automatic bit1(input logic d);
    line(1'b0, d);
    line(1'b1, d);
    line(1'b0, d);
  endtask
  task automatic start();
    line(1'b1, 1'b1);
    line(1'b1, 1'b0);
    line(1'b0, 1'b0);
  endtask
  task automatic stop();
    line(1'b0, 1'b0);
    line(1'b1, 1'b0);
    line(1'b1, 1'b1);
  endtask
  // eight clocks, then the ninth rise left high for the caller to look at
  task automatic byte9(input logic [7:0] b, input logic a);
    for (int i = 7; i >= 0; i--)
      bit1(b[i]);
    line(1'b0, a);
    line(1'b1, a);
  endtask
endmodule

// >>> bench/tb_top.sv
// tb_top: self-checking bench of the status flag block
// assumes tsf_bus_peer plays the remote party and tsf_chk is bound in
`timescale 1ns/100ps
`include "tsf_defines.svh"
module tb_top;
  import tsf_pkg::*;
  // design inputs
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic so_latch = 1'b1;
  logic start_gen = 1'b0;
  logic wait_ninth = 1'b0;
  logic arb_lost = 1'b0;
  // design outputs and bus levels
  logic [7:0] rdata;
  logic sda_out, sda_oe_n, irq, scl, sda;
  tsf_flags_t flags;
  logic [7:0] v;
  int err_total = 0;
  int tests_run = 0;
  // slave rows: address byte, ninth bit, flags {start, ack, dir} after the ninth rise
  typedef struct packed {logic [7:0] b; logic a; logic [2:0] f;} tsf_row_t;
  tsf_row_t rows [4] = '{'{8'hA1, 1'b0, 3'h7}, '{8'hA0, 1'b0, 3'h6},
    '{8'hA1, 1'b1, 3'h5}, '{8'h00, 1'b1, 3'h4}};
  always #20 clk = ~clk;
  tsf_status_flags i_dut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE_N(sda_oe_n), .SO_LATCH(so_latch), .START_GEN(start_gen),
    .WAIT_NINTH(wait_ninth), .ARB_LOST(arb_lost), .FLAGS(flags), .IRQ(irq));
  tsf_bus_peer i_peer (.clk(clk), .dev_out(sda_out), .dev_oe_n(sda_oe_n), .scl(scl),
    .sda(sda));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // flags are looked at just after the edge has settled
  task automatic fl(input logic [2:0] e);
    #1 chk("flags", {5'h00, e}, {5'h00, flags});
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic stop_test();
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // longest path is a few thousand cycles; this leaves ample margin
  initial
  begin
    w(30000);
    err_total++;
    stop_test();
  end
  initial
  begin
    w(16);
    resetn <= 1'b1;
    w(8);
    fl(3'h0);
    #1 chk("oe_n", 8'h01, {7'h00, sda_oe_n});
    rd_reg(8'h30, v);
    chk("unmapped", 8'h00, v);
    // slave address bytes, the peer getting slower row by row
    wr_reg(`TSF_OFS_CTRL, 8'h01);
    foreach (rows[i])
    begin
      i_peer.half = 7 + 4 * i;
      i_peer.start();
      i_peer.byte9(rows[i].b, rows[i].a);
      fl(rows[i].f);
      rd_reg(`TSF_OFS_FLAGS, v);
      chk("flag_reg", {5'h00, rows[i].f}, {5'h00, v[2:0]});
      i_peer.line(1'b0, rows[i].a);
      i_peer.stop();
      fl(3'h0);
    end
    // slave transmit: drive after the ninth fall, next rise clears ack and start
    i_peer.start();
    i_peer.byte9(8'hA1, 1'b0);
    i_peer.line(1'b0, 1'b0);
    i_peer.line(1'b0, 1'b1);
    #1 chk("oe_n", 8'h00, {7'h00, sda_oe_n});
    i_peer.line(1'b1, 1'b1);
    fl(3'h1);
    wait_ninth <= 1'b1;
    wr_reg(`TSF_OFS_CTRL, 8'h09);
    w(2);
    // wait stays active through the cycle in which the release pulse acts
    wait_ninth <= 1'b0;
    fl(3'h0);
    #1 chk("oe_n", 8'h01, {7'h00, sda_oe_n});
    i_peer.line(1'b0, 1'b1);
    i_peer.stop();
    // register write to the flags, then disable in mid address
    i_peer.start();
    fl(3'h4);
    wr_reg(`TSF_OFS_FLAGS, 8'hFF);
    w(2);
    fl(3'h4);
    wr_reg(`TSF_OFS_CTRL, 8'h00);
    w(2);
    fl(3'h0);
    i_peer.stop();
    // master: start generation, arbitration loss, low then high direction bit
    wr_reg(`TSF_OFS_CTRL, 8'h03);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      start_gen <= 1'b1;
      @(posedge clk);
      start_gen <= 1'b0;
      w(2);
      fl(3'h1);
      arb_lost <= ~k[0];
      w(3);
      fl({2'b00, k[0]});
      arb_lost <= 1'b0;
      i_peer.start();
      for (int i = 7; i >= 0; i--)
      begin
        so_latch <= i[0] ? 1'b0 : k[0];
        i_peer.bit1(1'b1);
      end
      so_latch <= 1'b1;
      fl({2'b10, ~k[0]});
      wr_reg(`TSF_OFS_CTRL, 8'h07);
      w(2);
      fl(3'h0);
      i_peer.stop();
    end
    // interrupt: raise, mask, unmask, clear
    wr_reg(`TSF_OFS_ISTAT, 8'h0F);
    wr_reg(`TSF_OFS_IMASK, 8'h01);
    i_peer.start();
    #1 chk("irq", 8'h01, {7'h00, irq});
    wr_reg(`TSF_OFS_IMASK, 8'h00);
    w(2);
    #1 chk("irq", 8'h00, {7'h00, irq});
    rd_reg(`TSF_OFS_ISTAT, v);
    chk("istat", 8'h01, v & 8'h01);
    wr_reg(`TSF_OFS_IMASK, 8'h01);
    w(2);
    #1 chk("irq", 8'h01, {7'h00, irq});
    wr_reg(`TSF_OFS_ISTAT, 8'h01);
    w(2);
    #1 chk("irq", 8'h00, {7'h00, irq});
    i_peer.stop();
    // mid-run reset with all three flags set clears them at once
    wr_reg(`TSF_OFS_CTRL, 8'h01);
    i_peer.start();
    i_peer.byte9(8'hA1, 1'b0);
    fl(3'h7);
    @(posedge clk);
    resetn <= 1'b0;
    w(2);
    fl(3'h0);
    @(posedge clk);
    resetn <= 1'b1;
    w(4);
    fl(3'h0);
    #1 chk("oe_n", 8'h01, {7'h00, sda_oe_n});
    stop_test();
  end
endmodule
